// file: hw/nvmspc_pkg.sv
// Constants, register map and types of the self-program controller
`default_nettype none
package nvmspc_pkg;
   // Register word offsets (byte addresses)
   localparam logic [7:0] ADR_CONTROL = 8'h00;
   localparam logic [7:0] ADR_UNLOCK = 8'h04;
   localparam logic [7:0] ADR_ADDR_LOW = 8'h08;
   localparam logic [7:0] ADR_ADDR_HIGH = 8'h0c;
   localparam logic [7:0] ADR_DATA_LOW = 8'h10;
   localparam logic [7:0] ADR_DATA_HIGH = 8'h14;
   localparam logic [7:0] ADR_IRQ_STATUS = 8'h18;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h1c;
   // Control register bit positions
   localparam int CTL_READ = 0;
   localparam int CTL_START = 1;
   localparam int CTL_PERMIT = 2;
   localparam int CTL_SPACE = 7;
   // Interrupt status bit positions
   localparam int IRQ_DONE = 0;
   // Unlock values
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'haa;
   // Block geometry
   localparam logic [2:0] BLOCK_LAST = 3'h7;
   localparam logic [3:0] ERASE_BASE = 4'h0;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [5:0] RST_DATA_HIGH = 6'h00;
   localparam logic [4:0] RST_ADDR_HIGH = 5'h00;
   // Power-up timer
   localparam int PWRT_MS = 64;
   localparam int CLK_HZ = 25_000_000;
   localparam int PWRT_CYCLES = PWRT_MS * (CLK_HZ / 1000);
   // Array commands
   typedef enum logic [1:0] {
      CMD_READ = 2'b00,
      CMD_WRITE = 2'b01,
      CMD_ERASE = 2'b10
   } nvmspc_cmd_e;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_EEWR = 3'b010,
      ST_ERASE = 3'b011,
      ST_PROG = 3'b100
   } nvmspc_state_e;
endpackage
`default_nettype wire

// file: hw/nvmspc_ctrl.sv
// Self-program controller for program flash and data EEPROM
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
module nvmspc_ctrl #(
   parameter int PWRT_COUNT = nvmspc_pkg::PWRT_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Interrupt
   output logic irq_o,
   // Array port
   output logic nv_req_o,
   output logic [1:0] nv_cmd_o,
   output logic nv_space_o,
   output logic [12:0] nv_addr_o,
   output logic [13:0] nv_wdata_o,
   input wire logic [13:0] nv_rdata_i,
   input wire logic nv_done_i,
   // Protection and external access
   input wire logic data_protect_fuse_i,
   input wire logic ext_prog_req_i,
   output logic ext_prog_grant_o
);
   nvmspc_pkg::nvmspc_state_e state;
   logic program_space_select, write_permit, write_start, read_start;
   logic [7:0] nvm_address_low;
   logic [4:0] nvm_address_high;
   logic [7:0] nvm_data_low;
   logic [5:0] nvm_data_high;
   logic [1:0] unlock_st;
   logic irq_status, irq_mask;
   logic [2:0] word_idx;
   logic [13:0] buf_mem [0:7];
   logic [20:0] pwrt_cnt;
   logic fuse_m, fuse_q, ext_m, ext_q;

   // Bus decode
   wire acc = cyc_i && stb_i && !ack_o;
   wire acc_wr = acc && we_i && sel_i[0];
   wire acc_rd = acc && !we_i;
   wire hit_ctl = adr_i == nvmspc_pkg::ADR_CONTROL;
   wire hit_unl = adr_i == nvmspc_pkg::ADR_UNLOCK;
   wire hit_al = adr_i == nvmspc_pkg::ADR_ADDR_LOW;
   wire hit_ah = adr_i == nvmspc_pkg::ADR_ADDR_HIGH;
   wire hit_dl = adr_i == nvmspc_pkg::ADR_DATA_LOW;
   wire hit_dh = adr_i == nvmspc_pkg::ADR_DATA_HIGH;
   wire hit_st = adr_i == nvmspc_pkg::ADR_IRQ_STATUS;
   wire hit_mk = adr_i == nvmspc_pkg::ADR_IRQ_MASK;
   wire busy = state != nvmspc_pkg::ST_IDLE || write_start || read_start;
   wire pwrt_busy = pwrt_cnt != 21'h0;
   wire ctl_wr = acc_wr && hit_ctl;
   wire unl_wr = acc_wr && hit_unl;
   wire new_space = busy ? program_space_select : dat_i[nvmspc_pkg::CTL_SPACE];
   wire pwrt_block = pwrt_busy && !new_space;
   wire start_go = ctl_wr && dat_i[nvmspc_pkg::CTL_START] && unlock_st == 2'h2
      && write_permit && !busy && !pwrt_block;
   wire read_go = ctl_wr && dat_i[nvmspc_pkg::CTL_READ] && !busy && !start_go;
   wire [12:0] full_addr = {nvm_address_high, nvm_address_low};
   wire [2:0] cur_idx = nvm_address_low[2:0];
   wire fl_last = cur_idx == nvmspc_pkg::BLOCK_LAST;
   wire finish_now = start_go && new_space && !fl_last;
   wire finish = finish_now || (state == nvmspc_pkg::ST_EEWR && nv_done_i)
      || (state == nvmspc_pkg::ST_PROG && nv_done_i && word_idx == nvmspc_pkg::BLOCK_LAST);
   wire clr_done = acc_wr && hit_st && dat_i[nvmspc_pkg::IRQ_DONE];
   wire [7:0] ctl_val = {program_space_select, 4'h0, write_permit, write_start, read_start};
   wire [7:0] rd_val = hit_ctl ? ctl_val :
      hit_al ? nvm_address_low :
      hit_ah ? {3'h0, nvm_address_high} :
      hit_dl ? nvm_data_low :
      hit_dh ? {2'h0, nvm_data_high} :
      hit_st ? {7'h0, irq_status} :
      hit_mk ? {7'h0, irq_mask} : nvmspc_pkg::RST_BYTE;

   // Bus answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0;
      end else begin
         ack_o <= acc;
         dat_o <= acc_rd ? {24'h0, rd_val} : 32'h0;
      end
   end

   // Synchronisers and external access gate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fuse_m <= 1'b0;
         fuse_q <= 1'b0;
         ext_m <= 1'b0;
         ext_q <= 1'b0;
         ext_prog_grant_o <= 1'b0;
      end else begin
         fuse_m <= data_protect_fuse_i;
         fuse_q <= fuse_m;
         ext_m <= ext_prog_req_i;
         ext_q <= ext_m;
         ext_prog_grant_o <= ext_q && fuse_q;
      end
   end

   // Power-up timer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwrt_cnt <= 21'(PWRT_COUNT);
      end else if (pwrt_busy) begin
         pwrt_cnt <= pwrt_cnt - 21'h1;
      end
   end

   // Unlock order tracker, no stored value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_st <= 2'h0;
      end else if (unl_wr) begin
         if (dat_i[7:0] == nvmspc_pkg::UNLOCK_FIRST) begin
            unlock_st <= 2'h1;
         end else if (dat_i[7:0] == nvmspc_pkg::UNLOCK_SECOND && unlock_st == 2'h1) begin
            unlock_st <= 2'h2;
         end else begin
            unlock_st <= 2'h0;
         end
      end else if (ctl_wr) begin
         unlock_st <= 2'h0;
      end
   end

   // Software registers; space select and address frozen while busy, permit and mask always writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         program_space_select <= 1'b0;
         write_permit <= 1'b0;
         nvm_address_low <= nvmspc_pkg::RST_BYTE;
         nvm_address_high <= nvmspc_pkg::RST_ADDR_HIGH;
         irq_mask <= 1'b0;
      end else begin
         if (ctl_wr) begin
            write_permit <= dat_i[nvmspc_pkg::CTL_PERMIT];
            program_space_select <= new_space;
         end
         if (acc_wr && hit_al && !busy) begin
            nvm_address_low <= dat_i[7:0];
         end
         if (acc_wr && hit_ah && !busy) begin
            nvm_address_high <= dat_i[4:0];
         end
         if (acc_wr && hit_mk) begin
            irq_mask <= dat_i[nvmspc_pkg::IRQ_DONE];
         end
      end
   end

   // Data registers, written by software or by a read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nvm_data_low <= nvmspc_pkg::RST_BYTE;
         nvm_data_high <= nvmspc_pkg::RST_DATA_HIGH;
      end else if (state == nvmspc_pkg::ST_READ && nv_done_i) begin
         nvm_data_low <= nv_rdata_i[7:0];
         if (program_space_select) begin
            nvm_data_high <= nv_rdata_i[13:8];
         end
      end else begin
         if (acc_wr && hit_dl && !busy) begin
            nvm_data_low <= dat_i[7:0];
         end
         if (acc_wr && hit_dh && !busy) begin
            nvm_data_high <= dat_i[5:0];
         end
      end
   end

   // Completion flag, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         irq_status <= finish || (irq_status && !clr_done);
         irq_o <= irq_status && irq_mask;
      end
   end

   // Word buffer
   always_ff @(posedge clk_i) begin
      if (start_go && new_space) begin
         buf_mem[cur_idx] <= {nvm_data_high, nvm_data_low};
      end
   end

   // Sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= nvmspc_pkg::ST_IDLE;
         write_start <= 1'b0;
         read_start <= 1'b0;
         word_idx <= 3'h0;
         nv_req_o <= 1'b0;
         nv_cmd_o <= nvmspc_pkg::CMD_READ;
         nv_space_o <= 1'b0;
         nv_addr_o <= 13'h0;
         nv_wdata_o <= 14'h0;
      end else begin
         nv_req_o <= 1'b0;
         if (finish) begin
            write_start <= 1'b0;
         end else if (start_go) begin
            write_start <= 1'b1;
         end
         case (state)
            nvmspc_pkg::ST_IDLE: begin
               if (start_go && !new_space) begin
                  state <= nvmspc_pkg::ST_EEWR;
                  nv_req_o <= 1'b1;
                  nv_cmd_o <= nvmspc_pkg::CMD_WRITE;
                  nv_space_o <= 1'b0;
                  nv_addr_o <= {5'h0, nvm_address_low};
                  nv_wdata_o <= {6'h0, nvm_data_low};
               end else if (start_go && fl_last) begin
                  state <= nvmspc_pkg::ST_ERASE;
                  nv_req_o <= 1'b1;
                  nv_cmd_o <= nvmspc_pkg::CMD_ERASE;
                  nv_space_o <= 1'b1;
                  nv_addr_o <= {full_addr[12:4], nvmspc_pkg::ERASE_BASE};
               end else if (read_go) begin
                  state <= nvmspc_pkg::ST_READ;
                  read_start <= 1'b1;
                  nv_req_o <= 1'b1;
                  nv_cmd_o <= nvmspc_pkg::CMD_READ;
                  nv_space_o <= new_space;
                  nv_addr_o <= new_space ? full_addr : {5'h0, nvm_address_low};
               end
            end
            nvmspc_pkg::ST_READ: begin
               if (nv_done_i) begin
                  state <= nvmspc_pkg::ST_IDLE;
                  read_start <= 1'b0;
               end
            end
            nvmspc_pkg::ST_EEWR: begin
               if (nv_done_i) begin
                  state <= nvmspc_pkg::ST_IDLE;
               end
            end
            nvmspc_pkg::ST_ERASE: begin
               if (nv_done_i) begin
                  state <= nvmspc_pkg::ST_PROG;
                  word_idx <= 3'h0;
                  nv_req_o <= 1'b1;
                  nv_cmd_o <= nvmspc_pkg::CMD_WRITE;
                  nv_addr_o <= {full_addr[12:3], 3'h0};
                  nv_wdata_o <= buf_mem[0];
               end
            end
            nvmspc_pkg::ST_PROG: begin
               if (nv_done_i && word_idx == nvmspc_pkg::BLOCK_LAST) begin
                  state <= nvmspc_pkg::ST_IDLE;
               end else if (nv_done_i) begin
                  word_idx <= word_idx + 3'h1;
                  nv_req_o <= 1'b1;
                  nv_addr_o <= {full_addr[12:3], word_idx + 3'h1};
                  nv_wdata_o <= buf_mem[word_idx + 3'h1];
               end
            end
            default: begin
               state <= nvmspc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_reset_permit_clear: assert property (disable iff (1'b0) rst_i |=> !write_permit)
      else $error("write permit not cleared by reset");
   a_start_after_unlock: assert property ($rose(write_start) |-> $past(unlock_st) == 2'h2)
      else $error("write started without unlock order");
   a_start_needs_permit: assert property ($rose(write_start) |-> $past(write_permit))
      else $error("write started without permit");
   a_pwrt_blocks_ee: assert property (pwrt_busy && state == nvmspc_pkg::ST_IDLE
      |=> state != nvmspc_pkg::ST_EEWR)
      else $error("eeprom write during power-up timer");
   a_fuse_refuse: assert property (!fuse_q |=> !ext_prog_grant_o)
      else $error("external access granted under protection");
   a_unlock_reads_zero: assert property (acc_rd && hit_unl |=> dat_o == 32'h0)
      else $error("unlock port returned data");
   a_unlock_break: assert property (unl_wr && dat_i[7:0] != nvmspc_pkg::UNLOCK_FIRST
      && dat_i[7:0] != nvmspc_pkg::UNLOCK_SECOND |=> unlock_st == 2'h0)
      else $error("unlock tracker kept a broken order");
   a_ee_byte_addr: assert property (nv_req_o && !nv_space_o |-> nv_addr_o[12:8] == 5'h0)
      else $error("eeprom access wider than a byte address");
   a_done_clears_start: assert property (finish |=> !write_start && irq_status)
      else $error("completion did not clear start and set flag");
   a_block_erase_first: assert property (start_go && new_space && fl_last
      |=> nv_req_o && nv_cmd_o == nvmspc_pkg::CMD_ERASE && nv_addr_o[3:0] == 4'h0)
      else $error("block write did not begin with erase");
   a_busy_addr_hold: assert property (busy && acc_wr && hit_al |=> $stable(nvm_address_low))
      else $error("address changed during a write");

   c_ee_write: cover property (state == nvmspc_pkg::ST_EEWR ##1 state == nvmspc_pkg::ST_IDLE);
   c_block_prog: cover property (state == nvmspc_pkg::ST_PROG && finish);
   c_read_done: cover property (state == nvmspc_pkg::ST_READ && nv_done_i);
   c_irq_raised: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// file: sim/nvmspc_array_model.sv
// Behavioural model of the flash and data EEPROM arrays
`default_nettype none
module nvmspc_array_model #(
   parameter int LAT = 6
) (
   // Clock
   input wire logic clk_i,
   // Command side
   input wire logic nv_req_i,
   input wire logic [1:0] nv_cmd_i,
   input wire logic nv_space_i,
   input wire logic [12:0] nv_addr_i,
   input wire logic [13:0] nv_wdata_i,
   // Answer side
   output logic [13:0] nv_rdata_o,
   output logic nv_done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] mem [0:16383];
   int cnt;
   wire logic [13:0] idx = {nv_space_i, nv_addr_i};
   initial begin
      cnt = 0;
      nv_done_o = 1'b0;
      nv_rdata_o = 14'h0000;
      for (int j = 0; j < 16384; j++) begin
         mem[j] = 14'h3fff;
      end
   end
   always @(posedge clk_i) begin
      nv_done_o <= 1'b0;
      nv_rdata_o <= ~nv_rdata_o;
      if (nv_req_i === 1'b1) begin
         cnt <= LAT;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         nv_done_o <= 1'b1;
         case (nv_cmd_i)
            2'b00: nv_rdata_o <= mem[idx];
            2'b01: mem[idx] <= nv_space_i ? nv_wdata_i : {6'h00, nv_wdata_i[7:0]};
            2'b10: begin
               for (int j = 0; j < 16; j++) begin
                  mem[{1'b1, nv_addr_i[12:4], j[3:0]}] <= 14'h3fff;
               end
            end
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: sim/nvm_self_program_control_tb.sv
// Register-level testbench of the self-program controller
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s expected %h got %h", nm, e, g); end end
module nvm_self_program_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PWRT = 40;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic fuse = 1'b1, ext_req = 1'b1;
   logic [31:0] dat_o;
   logic ack_o, irq_o, nv_req_o, nv_space_o, nv_done_i, grant, w_space;
   logic [1:0] nv_cmd_o;
   logic [12:0] nv_addr_o, er_addr, w_addr;
   logic [13:0] nv_wdata_o, nv_rdata_i, w_data;
   logic [7:0] q;
   int errors = 0, n_checks = 0, n_wr = 0, n_er = 0, cyc_cnt = 0;
   always #20 clk_i = ~clk_i;
   nvmspc_ctrl #(.PWRT_COUNT(PWRT)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .irq_o(irq_o), .nv_req_o(nv_req_o), .nv_cmd_o(nv_cmd_o),
      .nv_space_o(nv_space_o), .nv_addr_o(nv_addr_o), .nv_wdata_o(nv_wdata_o),
      .nv_rdata_i(nv_rdata_i), .nv_done_i(nv_done_i), .data_protect_fuse_i(fuse),
      .ext_prog_req_i(ext_req), .ext_prog_grant_o(grant));
   nvmspc_array_model #(.LAT(6)) arr (.clk_i(clk_i), .nv_req_i(nv_req_o),
      .nv_cmd_i(nv_cmd_o), .nv_space_i(nv_space_o), .nv_addr_i(nv_addr_o),
      .nv_wdata_i(nv_wdata_o), .nv_rdata_o(nv_rdata_i), .nv_done_o(nv_done_i));
   // Run ceiling, counted as a mismatch
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         errors++;
         results();
      end
   end
   // Array command monitor
   always @(posedge clk_i) begin
      if (nv_req_o === 1'b1 && nv_cmd_o === 2'b01) begin
         n_wr++;
         w_addr = nv_addr_o;
         w_data = nv_wdata_o;
         w_space = nv_space_o;
      end
      if (nv_req_o === 1'b1 && nv_cmd_o === 2'b10) begin
         n_er++;
         er_addr = nv_addr_o;
      end
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      `CHK(nm, e, q)
   endtask
   task automatic go(input logic [7:0] ctl);
      wb(1'b1, nvmspc_pkg::ADR_UNLOCK, nvmspc_pkg::UNLOCK_FIRST);
      wb(1'b1, nvmspc_pkg::ADR_UNLOCK, nvmspc_pkg::UNLOCK_SECOND);
      wb(1'b1, nvmspc_pkg::ADR_CONTROL, ctl);
      @(posedge clk_i);
   endtask
   task automatic wait_idle();
      do begin
         wb(1'b0, nvmspc_pkg::ADR_CONTROL, 8'h00);
      end while (q[1:0] !== 2'b00);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rd("control", nvmspc_pkg::ADR_CONTROL, 8'h00);
      wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h04);
      go(8'h06);
      rd("start pwrt", nvmspc_pkg::ADR_CONTROL, 8'h04);
      `CHK("writes pwrt", 0, n_wr)
      repeat (PWRT) @(posedge clk_i);
      rd("unlock", nvmspc_pkg::ADR_UNLOCK, 8'h00);
      rd("unmapped", 8'h20, 8'h00);
      `CHK("grant", 1'b1, grant)
      fuse <= 1'b0;
      wb(1'b1, nvmspc_pkg::ADR_UNLOCK, nvmspc_pkg::UNLOCK_FIRST);
      wb(1'b1, nvmspc_pkg::ADR_UNLOCK, 8'h12);
      wb(1'b1, nvmspc_pkg::ADR_UNLOCK, nvmspc_pkg::UNLOCK_SECOND);
      wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h06);
      rd("bad order", nvmspc_pkg::ADR_CONTROL, 8'h04);
      `CHK("grant off", 1'b0, grant)
      wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h00);
      go(8'h02);
      rd("no permit", nvmspc_pkg::ADR_CONTROL, 8'h00);
      `CHK("writes refused", 0, n_wr)
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, nvmspc_pkg::ADR_IRQ_MASK, i[7:0]);
         wb(1'b1, nvmspc_pkg::ADR_ADDR_LOW, 8'h05 + i[7:0]);
         wb(1'b1, nvmspc_pkg::ADR_DATA_LOW, 8'ha5 ^ i[7:0]);
         wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h04);
         go(8'h06);
         wb(1'b1, nvmspc_pkg::ADR_DATA_LOW, 8'h00);
         wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h00);
         rd("data busy", nvmspc_pkg::ADR_DATA_LOW, 8'ha5 ^ i[7:0]);
         wait_idle();
         rd("status", nvmspc_pkg::ADR_IRQ_STATUS, 8'h01);
         `CHK("irq", i[0], irq_o)
         `CHK("ee addr", 13'h0005 + i[12:0], w_addr)
         `CHK("ee data", 8'ha5 ^ i[7:0], w_data[7:0])
         `CHK("ee space", 1'b0, w_space)
         wb(1'b1, nvmspc_pkg::ADR_IRQ_STATUS, 8'h01);
         rd("status clr", nvmspc_pkg::ADR_IRQ_STATUS, 8'h00);
         `CHK("irq clr", 1'b0, irq_o)
      end
      `CHK("ee writes", 2, n_wr)
      for (int i = 0; i < 2; i++) begin
         wb(1'b1, nvmspc_pkg::ADR_ADDR_LOW, 8'h05 + i[7:0]);
         wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h01);
         wait_idle();
         rd("verify", nvmspc_pkg::ADR_DATA_LOW, 8'ha5 ^ i[7:0]);
      end
      wb(1'b1, nvmspc_pkg::ADR_ADDR_HIGH, 8'h01);
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, nvmspc_pkg::ADR_ADDR_LOW, 8'h10 + i[7:0]);
         wb(1'b1, nvmspc_pkg::ADR_DATA_LOW, 8'h30 + i[7:0]);
         wb(1'b1, nvmspc_pkg::ADR_DATA_HIGH, 8'h15);
         wb(1'b1, nvmspc_pkg::ADR_IRQ_STATUS, 8'h01);
         wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h84);
         go(8'h86);
         rd("word flag", nvmspc_pkg::ADR_IRQ_STATUS, {7'h0, i < 7});
         if (i < 7) `CHK("buffered", 2, n_wr)
      end
      wb(1'b1, nvmspc_pkg::ADR_ADDR_LOW, 8'h00);
      wait_idle();
      rd("addr hold", nvmspc_pkg::ADR_ADDR_LOW, 8'h17);
      rd("addr high", nvmspc_pkg::ADR_ADDR_HIGH, 8'h01);
      `CHK("erase count", 1, n_er)
      `CHK("erase addr", 13'h0110, er_addr)
      `CHK("prog count", 10, n_wr)
      `CHK("prog addr", 13'h0117, w_addr)
      `CHK("prog space", 1'b1, w_space)
      rd("flash done", nvmspc_pkg::ADR_IRQ_STATUS, 8'h01);
      wb(1'b1, nvmspc_pkg::ADR_ADDR_LOW, 8'h13);
      wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h81);
      wait_idle();
      rd("flash low", nvmspc_pkg::ADR_DATA_LOW, 8'h33);
      rd("flash high", nvmspc_pkg::ADR_DATA_HIGH, 8'h15);
      fuse <= 1'b1;
      ext_req <= 1'b0;
      wb(1'b1, nvmspc_pkg::ADR_CONTROL, 8'h04);
      repeat (4) @(posedge clk_i);
      `CHK("grant idle", 1'b0, grant)
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd("control reset", nvmspc_pkg::ADR_CONTROL, 8'h00);
      results();
   end
endmodule
`default_nettype wire
